// >>> include/asm_pkg.sv
// Constants and register layout of the alarm status and mask block.
// Operation
// - After reset the alarm flags read 0x1F, reserved bits cleared.
// - Bit 4 sets whenever the PLL reports it is not locked.
// - Bit 3 sets while the link is enabled but not in data encoding.
// - Bit 2 sets when a SYSREF event realigns the internal clocks.
// - Bit 1 sets on link disable, oscillator sync, or accumulator mismatch.
// - Bit 0 sets whenever the channel A and B divider states differ.
// - Writing one clears that flag; flags written with zero stay unchanged.
// - After reset the alarm mask reads 0x1F, every alarm masked.
// - Mask bit shares its flag's position; a set mask hides that flag.
// - Summary bit 0 reads one while any unmasked flag is set.
// - When selected, the summary alarm drives the calibration status pin.
package asm_pkg;
  localparam int NFLAGS = 5;
  localparam int ADDR_W = 12;
  localparam int ACC_W = 32;
  localparam int DIV_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SUMMARY = 10'h2C0;
  localparam logic [9:0] IDX_FLAGS = 10'h2C1;
  localparam logic [9:0] IDX_MASK = 10'h2C2;
  localparam logic [9:0] IDX_PIN_SEL = 10'h2C3;

  // Field positions
  localparam int BIT_DIV = 0;
  localparam int BIT_OSC = 1;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_LINK = 3;
  localparam int BIT_PLL = 4;
  localparam int BIT_SUMMARY = 0;
  localparam int BIT_PIN_SEL = 0;
  localparam int RSV_LSB = 5;
  localparam int RSV_MSB = 7;

  // Reset values
  localparam logic [NFLAGS-1:0] FLAGS_RST = 5'h1F;
  localparam logic [2:0] RSV_RST = 3'h0;
  localparam logic [7:0] MASK_RST = 8'h1F;
  localparam logic PIN_SEL_RST = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> include/asm_flag_if.sv
// Set, clear and state vectors between the register logic and the flag bank.
`timescale 1ns/1ps
interface asm_flag_if;
  import asm_pkg::*;
  logic [NFLAGS-1:0] set;
  logic [NFLAGS-1:0] clr;
  logic [NFLAGS-1:0] q;
  modport bank (input set, input clr, output q);
  modport ctrl (output set, output clr, input q);
endinterface

// >>> src/asm_flag_bank.sv
// Bank of sticky alarm flags, one flip-flop per alarm.
`timescale 1ns/1ps
module asm_flag_bank
  import asm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  asm_flag_if.bank fl
);
  genvar i;
  // One sticky bit per alarm; a live condition beats a clear
  generate
    for (i = 0; i < NFLAGS; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fl.q[i] <= FLAGS_RST[i];
        end else begin
          fl.q[i] <= fl.set[i] | (fl.q[i] & ~fl.clr[i]);
        end
      end
    end
  endgenerate
endmodule

// >>> src/asm_alarm_top.sv
// Alarm flag, mask and summary block with an AXI4-Lite register slave.
`timescale 1ns/1ps
module asm_alarm_top
  import asm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pll_locked,
  input wire logic link_enable,
  input wire logic data_encoding_state,
  input wire logic realign_event,
  input wire logic osc_sync_event,
  input wire logic [ACC_W-1:0] osc_acc_a,
  input wire logic [ACC_W-1:0] osc_acc_b,
  input wire logic [DIV_W-1:0] div_state_a,
  input wire logic [DIV_W-1:0] div_state_b,
  input wire logic cal_status_in,
  output logic calibration_status_pin,
  output logic alarm_irq
);
  asm_flag_if fl ();

  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [2:0] flags_rsv_reg;
  logic [7:0] mask_reg;
  logic pin_sel_reg;
  logic irq_reg;
  logic pin_reg;

  // Handshake readies; one write and one read in flight at most
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Write decode on the held address; misaligned bytes count as unmapped
  wire [9:0] wr_idx = aw_addr_reg[ADDR_W-1:2];
  wire wr_aligned = aw_addr_reg[1:0] == 2'h0;
  wire wr_hit_sum = wr_aligned && (wr_idx == IDX_SUMMARY);
  wire wr_hit_flags = wr_aligned && (wr_idx == IDX_FLAGS);
  wire wr_hit_mask = wr_aligned && (wr_idx == IDX_MASK);
  wire wr_hit_sel = wr_aligned && (wr_idx == IDX_PIN_SEL);
  wire wr_hit = wr_hit_sum || wr_hit_flags || wr_hit_mask || wr_hit_sel;
  wire lane0 = w_strb_reg[0];
  wire wr_flags_en = do_write && wr_hit_flags && lane0;
  wire wr_mask_en = do_write && wr_hit_mask && lane0;
  wire wr_sel_en = do_write && wr_hit_sel && lane0;

  // Alarm conditions are levels; a held condition keeps its flag set
  wire acc_mismatch = osc_acc_a != osc_acc_b;
  wire div_mismatch = div_state_a != div_state_b;
  wire set_pll = !pll_locked;
  wire set_link = link_enable && !data_encoding_state;
  wire set_realign = realign_event;
  wire set_osc = !link_enable || osc_sync_event || acc_mismatch;
  wire set_div = div_mismatch;
  assign fl.set = {set_pll, set_link, set_realign, set_osc, set_div};
  // Only ones written to the flag register clear anything
  assign fl.clr = wr_flags_en ? w_data_reg[NFLAGS-1:0] : '0;

  // Summary: flags whose mask bit is zero, ORed together
  wire [NFLAGS-1:0] unmasked = fl.q & ~mask_reg[NFLAGS-1:0];
  wire summary = |unmasked;
  wire pin_next = pin_sel_reg ? summary : cal_status_in;

  // Read decode straight off the request address
  wire [9:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_aligned = s_axi_araddr[1:0] == 2'h0;
  wire rd_hit_sum = rd_aligned && (rd_idx == IDX_SUMMARY);
  wire rd_hit_flags = rd_aligned && (rd_idx == IDX_FLAGS);
  wire rd_hit_mask = rd_aligned && (rd_idx == IDX_MASK);
  wire rd_hit_sel = rd_aligned && (rd_idx == IDX_PIN_SEL);
  wire rd_hit = rd_hit_sum || rd_hit_flags || rd_hit_mask || rd_hit_sel;
  wire [7:0] rd_byte =
    rd_hit_sum ? {7'h00, summary} :
    rd_hit_flags ? {flags_rsv_reg, fl.q} :
    rd_hit_mask ? mask_reg :
    rd_hit_sel ? {7'h00, pin_sel_reg} : 8'h00;

  asm_flag_bank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .fl(fl)
  );

  // Write address holding register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Write data holding register; may arrive before or after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; data captured at the address handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Reserved flag bits are plain storage, not write-one-to-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_rsv_reg <= RSV_RST;
    end else if (wr_flags_en) begin
      flags_rsv_reg <= w_data_reg[RSV_MSB:RSV_LSB];
    end
  end

  // Mask register, all alarms masked out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= MASK_RST;
    end else if (wr_mask_en) begin
      mask_reg <= w_data_reg[7:0];
    end
  end

  // Pin route select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sel_reg <= PIN_SEL_RST;
    end else if (wr_sel_en) begin
      pin_sel_reg <= w_data_reg[BIT_PIN_SEL];
    end
  end

  // Outputs registered so the pin never glitches on decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      irq_reg <= summary;
      pin_reg <= pin_next;
    end
  end
  assign alarm_irq = irq_reg;
  assign calibration_status_pin = pin_reg;

  // Checks on reset values, flag setting, clearing and the summary path
  flags_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (fl.q == FLAGS_RST) && (flags_rsv_reg == RSV_RST))
    else $error("flags not at reset value after reset");

  mask_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (mask_reg == MASK_RST) && !alarm_irq)
    else $error("mask not at reset value after reset");

  pll_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pll_locked |=> fl.q[BIT_PLL])
    else $error("pll unlock flag not set");

  link_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    link_enable && !data_encoding_state |=> fl.q[BIT_LINK])
    else $error("link down flag not set");

  realign_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    realign_event |=> fl.q[BIT_REALIGN])
    else $error("realignment flag not set");

  osc_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!link_enable || osc_sync_event || (osc_acc_a != osc_acc_b))
    |=> fl.q[BIT_OSC])
    else $error("oscillator phase flag not set");

  div_flag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (div_state_a != div_state_b) |=> fl.q[BIT_DIV])
    else $error("divider mismatch flag not set");

  clear_only_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_flags_en |=>
    (fl.q == ($past(fl.set) | ($past(fl.q) & ~$past(w_data_reg[4:0])))))
    else $error("flag clear touched wrong bits");

  set_wins_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (fl.set & fl.clr) != '0 |=> (fl.q & $past(fl.set)) == $past(fl.set))
    else $error("clear beat a live alarm");

  flag_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_flags_en |=> (fl.q & $past(fl.q)) == $past(fl.q))
    else $error("flag dropped without a clear");

  summary_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 alarm_irq == $past(|(fl.q & ~mask_reg[4:0])))
    else $error("interrupt does not follow unmasked flags");

  pin_route_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    pin_sel_reg && summary |=> calibration_status_pin)
    else $error("summary not routed to status pin");

  reserved_store_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_mask_en |=> mask_reg[7:5] == $past(w_data_reg[7:5]) ##1
    mask_reg[7:5] == $past(w_data_reg[7:5], 2))
    else $error("reserved mask bits not stored");

  // Bus answers: read data one cycle after the address, response after write
  read_answer_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");

  write_answer_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing after write");

  unmapped_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    do_write && !wr_hit |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not answered with error");

  flags_rsv_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_flags_en |=> flags_rsv_reg == $past(w_data_reg[RSV_MSB:RSV_LSB]))
    else $error("reserved flag bits not stored");

  // Sampled reset term keeps the release edge from judging a reset pin
  pin_pass_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rst_n && !pin_sel_reg |=> calibration_status_pin == $past(cal_status_in))
    else $error("status pin does not follow its input");

  masked_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (&mask_reg[NFLAGS-1:0]) |=> !alarm_irq)
    else $error("interrupt raised with all alarms masked");
endmodule

// >>> sim/tb.sv
// Self-checking bench for the alarm flag, mask and summary block.
`timescale 1ns/1ps
module tb;
  import asm_pkg::*;
  logic clk, rst_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic pll_locked, link_enable, data_encoding_state, realign_event;
  logic osc_sync_event, cal_status_in, calibration_status_pin, alarm_irq;
  logic [ACC_W-1:0] osc_acc_a, osc_acc_b;
  logic [DIV_W-1:0] div_state_a, div_state_b;
  int fail_count, checks_done, mflags, mmask, msel, b;
  // Flag bit raised by each stimulus case
  int bitof [7] = '{0, 1, 1, 1, 2, 3, 4};
  localparam logic [11:0] A_SUM = {IDX_SUMMARY, 2'b00};
  localparam logic [11:0] A_FLG = {IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_MSK = {IDX_MASK, 2'b00};
  localparam logic [11:0] A_SEL = {IDX_PIN_SEL, 2'b00};
  localparam logic [11:0] A_BAD = 12'hB10;

  asm_alarm_top u_asm_alarm_top (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pll_locked, .link_enable, .data_encoding_state,
    .realign_event, .osc_sync_event, .osc_acc_a, .osc_acc_b, .div_state_a,
    .div_state_b, .cal_status_in, .calibration_status_pin, .alarm_irq
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected summary from the model flags and mask
  function automatic logic [31:0] msum();
    return ((mflags & ~mmask & 'h1F) != 0);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Requests change just after a rising edge; handshakes judged at the next
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Write and keep the model in step; reserved flag bits store plainly
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    chk(resp, RESP_OKAY);
    if (a == A_FLG) mflags = (mflags & ~int'(d) & 'h1F) | (int'(d) & 'hE0);
    if (a == A_MSK) mmask = int'(d) & 'hFF;
    if (a == A_SEL) msel = int'(d) & 1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_read(a, rd, resp);
    chk(resp, RESP_OKAY);
    chk(rd, exp);
  endtask

  task automatic sum_chk();
    rd_chk(A_SUM, msum());
    chk(alarm_irq, msum());
    if (msel != 0) chk(calibration_status_pin, msum());
    else chk(calibration_status_pin, cal_status_in);
  endtask

  // Drive one alarm condition on or off; case 3 also shows no link alarm
  task automatic cond(input int k, input logic on);
    case (k)
      0: div_state_b <= on ? div_state_a ^ 8'h01 : div_state_a;
      1: osc_acc_b <= on ? osc_acc_a ^ 32'h00000001 : osc_acc_a;
      2: osc_sync_event <= on;
      3: begin
        link_enable <= !on;
        data_encoding_state <= !on;
      end
      4: realign_event <= on;
      5: data_encoding_state <= !on;
      default: pll_locked <= !on;
    endcase
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'd21;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, realign_event, osc_sync_event} = '0;
    {pll_locked, link_enable, data_encoding_state} = 3'h7;
    div_state_a = DIV_W'(xs());
    div_state_b = div_state_a;
    osc_acc_a = xs();
    osc_acc_b = osc_acc_a;
    // High, so a pin that wrongly shows the idle summary is caught
    cal_status_in = 1'b1;
    {fail_count, checks_done, msel} = '0;
    mflags = 'h1F;
    mmask = 'h1F;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(A_FLG, 'h1F);
    rd_chk(A_MSK, 'h1F);
    rd_chk(A_SEL, 0);
    sum_chk();
    wr(A_FLG, 'hFF);
    rd_chk(A_FLG, mflags);
    wr(A_MSK, xs());
    rd_chk(A_MSK, mmask);
    wr(A_MSK, 0);
    wr(A_SEL, 1);
    for (int k = 0; k < 7; k++) begin
      b = bitof[k];
      @(posedge clk);
      cond(k, 1'b1);
      @(posedge clk);
      cond(k, 1'b0);
      mflags = mflags | (1 << b);
      repeat (3) @(posedge clk);
      rd_chk(A_FLG, mflags);
      sum_chk();
      wr(A_FLG, ~(1 << b) & 'h1F);
      rd_chk(A_FLG, mflags);
      wr(A_MSK, 1 << b);
      sum_chk();
      wr(A_MSK, 0);
      wr(A_FLG, 1 << b);
      sum_chk();
    end
    // Clear while the unlock condition persists: the set must win
    @(posedge clk);
    cond(6, 1'b1);
    wr(A_FLG, 'h10);
    mflags = mflags | 'h10;
    rd_chk(A_FLG, mflags);
    @(posedge clk);
    cond(6, 1'b0);
    wr(A_FLG, 'h10);
    rd_chk(A_FLG, mflags);
    wr(A_SUM, 'hFF);
    sum_chk();
    axi_write(A_BAD, 'h1F, resp);
    chk(resp, RESP_SLVERR);
    axi_read(A_BAD, rd, resp);
    chk(resp, RESP_SLVERR);
    chk(rd, 0);
    // Misaligned byte address inside a mapped word is refused too
    axi_read(A_FLG + 12'h001, rd, resp);
    chk(resp, RESP_SLVERR);
    chk(rd, 0);
    wr(A_SEL, 0);
    sum_chk();
    tally_and_finish();
  end
endmodule
